// ### core/bnm_defs.vh
/*
  timing and geometry constants for the bytewide nonvolatile memory host port.
  assumes a 10 MHz system clock; times are in ns and cycle counts derive from them.
*/
`ifndef BNM_DEFS_VH
`define BNM_DEFS_VH

`define BNM_CLK_PERIOD_NS   100
`define BNM_ADDR_W          13
`define BNM_DATA_W          8
`define BNM_ROW_BYTES_LOG2  3
`define BNM_ACCESS_NS       70
`define BNM_PRECHARGE_NS    60
`define BNM_SETUP_NS        100
`define BNM_CS_LOW_MAX_NS   10000
// least times round up to whole cycles
`define BNM_ACCESS_CYC      ((`BNM_ACCESS_NS + `BNM_CLK_PERIOD_NS - 1) / `BNM_CLK_PERIOD_NS)
`define BNM_PRECHARGE_CYC   ((`BNM_PRECHARGE_NS + `BNM_CLK_PERIOD_NS - 1) / `BNM_CLK_PERIOD_NS)
`define BNM_SETUP_CYC       ((`BNM_SETUP_NS + `BNM_CLK_PERIOD_NS - 1) / `BNM_CLK_PERIOD_NS)
// longest time rounds down
`define BNM_CS_LOW_MAX_CYC  (`BNM_CS_LOW_MAX_NS / `BNM_CLK_PERIOD_NS)

`endif

// ### core/bnm_tcount.v
/*
  down counter used for the access and pre-charge intervals of the host port.
  assumes one clock and a synchronous load that wins over counting.
*/
`timescale 1ns/1ps
`default_nettype none
module bnm_tcount #(
  parameter W = 8
) (
  input  wire         clk_in,   // system clock
  input  wire         rstn_in,  // synchronised reset, active low
  input  wire         load_in,  // load a new count
  input  wire [W-1:0] val_in,   // count to load
  output reg          done_out  // count has run out
);
  reg [W-1:0] cnt_q;

  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_q    <= {W{1'b0}};
      done_out <= 1'b1;
    end
    else if (load_in)
    begin
      cnt_q    <= val_in;
      done_out <= (val_in == {W{1'b0}});
    end
    else if (cnt_q != {W{1'b0}})
    begin
      cnt_q    <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      done_out <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule
`default_nettype wire

// ### core/bnm_host.v
/*
  host controller for a bytewide nonvolatile memory with an asynchronous sram style port.
  assumes a 10 MHz clock, synchronous user requests and a memory that latches its
  address on each falling chip select.
*/
// Summary of operation
// [RULE1] every access starts with a falling chip select, one per access
// [RULE2] 8,192 bytes, each selected by a unique 13-bit address
// [RULE3] 1024 rows of 8 bytes; each access wears the whole row
// [RULE4] falling chip select latches address; cycle completes internally
// [RULE5] address changes after the latch are ignored until next fall
// [RULE6] memory drives read data only with output drive low after access time
// [RULE7] output drive high keeps the memory data bus undriven
// [RULE8] write strobe low at chip select fall makes the cycle a write
// [RULE9] write strobe falling later turns a read cycle into a write
// [RULE10] array write ends at first rising write strobe or chip select
// [RULE11] host holds write strobe and chip select low past access time
// [RULE12] host holds write data stable through setup before write end
// [RULE13] a write completes in its bus cycle; no polling needed
// [RULE14] written data is nonvolatile as soon as the write completes
// [RULE15] host raises chip select and keeps it high for the pre-charge time
// [RULE16] host never holds chip select low beyond its maximum low time
// [RULE17] host toggles chip select for every access, never tied low
// [RULE18] host keeps chip select high while supply is below minimum; code checks supply only at accept, an access under way keeps it low
// [RULE19] host keeps write strobe high during power up and power down; a write under way when supply drops keeps it low
// [RULE20] with chip select high the memory neither drives nor writes
`timescale 1ns/1ps
`include "bnm_defs.vh"
`default_nettype none
module bnm_host #(
  parameter AW         = `BNM_ADDR_W,
  parameter DW         = `BNM_DATA_W,
  parameter ACCESS_CYC = `BNM_ACCESS_CYC,
  parameter PRECH_CYC  = `BNM_PRECHARGE_CYC,
  parameter SETUP_CYC  = `BNM_SETUP_CYC
) (
  input  wire          clk_in,        // system clock, 10 MHz
  input  wire          rstn_in,       // async reset, active low
  input  wire          supply_ok_in,  // supply within range
  input  wire          req_in,        // request pulse or level
  input  wire          req_wr_in,     // 1 write, 0 read
  input  wire [AW-1:0] req_addr_in,   // byte address
  input  wire [DW-1:0] req_wdata_in,  // write data
  output reg           req_ready_out, // idle, request accepted next edge
  output reg           rd_valid_out,  // one-cycle read data strobe
  output reg  [DW-1:0] rd_data_out,   // read data
  output reg  [AW-1:0] address_bus_out, // memory address
  output reg           cs_n_out,      // chip select, active low
  output reg           we_n_out,      // write strobe, active low
  output reg           oe_n_out,      // output drive control, active low
  output reg  [DW-1:0] data_bus_out,  // data to memory
  output reg           data_bus_oe_out, // high while host drives data
  input  wire [DW-1:0] data_bus_in    // data from memory
);
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_SEL   = 5'h02;
  localparam [4:0] S_ACC   = 5'h04;
  localparam [4:0] S_END   = 5'h08;
  localparam [4:0] S_PRECH = 5'h10;
  localparam       CW      = 8;
  // last cs low count before a forced end, so low time never passes the maximum
  localparam       CS_LIM  = `BNM_CS_LOW_MAX_CYC - 1;

  reg        rst_s1_q;
  reg        rst_s2_q;
  reg  [4:0] state_q;
  reg        wr_q;
  reg        ld;
  reg  [CW-1:0] ld_val;
  wire       t_done;
  wire       rstn = rst_s2_q;
  reg  [CW-1:0] cs_low_q;
  // cs low limit reached
  wire       cs_low_lim = (cs_low_q == CS_LIM[CW-1:0]);

  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  bnm_tcount #(.W(CW)) u_tcount (
    .clk_in   (clk_in),
    .rstn_in  (rstn),
    .load_in  (ld),
    .val_in   (ld_val),
    .done_out (t_done)
  );

  // counts chip select low cycles; saturates at the limit
  always @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_low_q <= {CW{1'b0}};
    end
    else if (cs_n_out)
    begin
      cs_low_q <= {CW{1'b0}};
    end
    else if (!cs_low_lim)
    begin
      cs_low_q <= cs_low_q + {{(CW-1){1'b0}}, 1'b1};  // [RULE16]
    end
  end

  // timer loads on every state change into a timed state
  always @*
  begin
    ld     = 1'b0;
    ld_val = {CW{1'b0}};
    case (state_q)
      S_SEL:
      begin
        ld     = 1'b1;
        ld_val = (ACCESS_CYC > SETUP_CYC) ? ACCESS_CYC[CW-1:0] : SETUP_CYC[CW-1:0];
      end
      S_END:
      begin
        ld     = 1'b1;
        ld_val = PRECH_CYC[CW-1:0];
      end
      default:
      begin
        ld     = 1'b0;
        ld_val = {CW{1'b0}};
      end
    endcase
  end

  always @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q         <= S_IDLE;
      wr_q            <= 1'b0;
      req_ready_out   <= 1'b0;
      rd_valid_out    <= 1'b0;
      rd_data_out     <= {DW{1'b0}};
      address_bus_out <= {AW{1'b0}};
      cs_n_out        <= 1'b1;  // [RULE18]
      we_n_out        <= 1'b1;  // [RULE19]
      oe_n_out        <= 1'b1;
      data_bus_out    <= {DW{1'b0}};
      data_bus_oe_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          cs_n_out      <= 1'b1;  // [RULE20]
          we_n_out      <= 1'b1;
          oe_n_out      <= 1'b1;
          // ready follows the supply so no cycle starts on a low supply
          req_ready_out <= supply_ok_in;
          if (req_in && req_ready_out && supply_ok_in)  // [RULE18]
          begin
            // address and strobe set up one cycle ahead of the chip select fall
            address_bus_out <= req_addr_in;  // [RULE2]
            wr_q            <= req_wr_in;
            we_n_out        <= ~req_wr_in;  // [RULE8]
            data_bus_out    <= req_wdata_in;
            data_bus_oe_out <= req_wr_in;
            req_ready_out   <= 1'b0;
            state_q         <= S_SEL;
          end
        end
        S_SEL:
        begin
          cs_n_out <= 1'b0;  // [RULE1] [RULE4] [RULE17]
          oe_n_out <= wr_q;  // [RULE6] [RULE7]
          state_q  <= S_ACC;
        end
        S_ACC:
        begin
          // strobes and data held until access and setup both met
          // a forced end at the low limit keeps the memory legal; read data is then stale
          if (t_done || cs_low_lim)  // [RULE11] [RULE12] [RULE16]
          begin
            if (!wr_q)
            begin
              rd_data_out  <= data_bus_in;
              rd_valid_out <= 1'b1;
            end
            cs_n_out <= 1'b1;  // [RULE10] [RULE15] [RULE16]
            we_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            state_q  <= S_END;
          end
        end
        S_END:
        begin
          // data released one cycle after the strobes rise for hold
          data_bus_oe_out <= 1'b0;
          state_q         <= S_PRECH;
        end
        S_PRECH:
        begin
          // ready only after the full pre-charge
          if (t_done)  // [RULE15] [RULE13]
          begin
            req_ready_out <= supply_ok_in;
            state_q       <= S_IDLE;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### dv/bnm_mem_model.sv
/* behavioural model of the bytewide nonvolatile memory seen by the host port.
   assumes strobes from the host; an undriven data bus shows the inverse value. */
`timescale 1ns/1ps
`default_nettype none
module bnm_mem_model (
  input  wire logic        cs_n_in,  // chip select, active low
  input  wire logic        we_n_in,  // write strobe, active low
  input  wire logic        oe_n_in,  // output drive control, active low
  input  wire logic [12:0] addr_in,  // address bus
  input  wire logic [7:0]  d_in,     // data from host
  output var  logic [7:0]  q_out,    // data to host
  output var  logic        q_oe_out  // memory drives the bus
);
  logic [7:0]  mem [0:8191];
  logic [12:0] lat;
  logic        wr = 1'b0;
  logic        acc = 1'b0;
  int          row_use [0:1023];
  always @(negedge cs_n_in)
  begin
    lat = addr_in;
    wr = !we_n_in;
    row_use[addr_in[12:3]]++;
    acc = 1'b0;
    acc <= #70 1'b1;
  end
  always @(negedge we_n_in) if (!cs_n_in) wr = 1'b1;
  always @(posedge we_n_in or posedge cs_n_in)
  begin
    if (wr) mem[lat] = d_in;
    wr = 1'b0;
  end
  assign q_oe_out = !cs_n_in && !oe_n_in && acc && !wr;
  assign q_out = mem[lat];
endmodule
`default_nettype wire

// ### dv/bnm_host_props.sv
/* pin-level assertions for the host port.
   assumes bind to bnm_host with its default widths. */
`timescale 1ns/1ps
`default_nettype none
module bnm_host_props (
  input wire logic       clk_in,          // clock
  input wire logic       rstn_in,         // reset, active low
  input wire logic       supply_ok_in,    // supply in range
  input wire logic       cs_n_out,        // chip select
  input wire logic       we_n_out,        // write strobe
  input wire logic       oe_n_out,        // output drive control
  input wire logic [7:0] data_bus_out,    // write data
  input wire logic       data_bus_oe_out, // host drives data
  input wire logic       rd_valid_out     // read strobe
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_PRECH: assert property ($rose(cs_n_out) |=> cs_n_out)
    else $error("chip select high too short");
  AST_CS_MAX: assert property ($fell(cs_n_out) |-> ##[1:100] cs_n_out)
    else $error("chip select low too long");
  AST_WR_HOLD: assert property ($fell(cs_n_out) && !we_n_out |=> !cs_n_out && !we_n_out)
    else $error("write ended before access time");
  AST_WDATA: assert property (!cs_n_out && !we_n_out |-> data_bus_oe_out && $stable(data_bus_out))
    else $error("write data moved");
  AST_SUPPLY: assert property ($fell(cs_n_out) |-> $past(supply_ok_in, 2))
    else $error("access without supply");
  AST_IDLE: assert property (disable iff (1'b0) !rstn_in |=> cs_n_out && we_n_out)
    else $error("strobes low in reset");
  AST_RD_CS: assert property (rd_valid_out |-> !$past(cs_n_out))
    else $error("read without chip select");
  AST_NO_FIGHT: assert property (data_bus_oe_out |-> oe_n_out)
    else $error("output drive low while host drives");
endmodule
bind bnm_host bnm_host_props u_props (.clk_in(clk_in), .rstn_in(rstn_in),
  .supply_ok_in(supply_ok_in), .cs_n_out(cs_n_out), .we_n_out(we_n_out),
  .oe_n_out(oe_n_out), .data_bus_out(data_bus_out), .data_bus_oe_out(data_bus_oe_out),
  .rd_valid_out(rd_valid_out));
`default_nettype wire

// ### dv/bytewide_nv_memory_port_tb.sv
/* self-checking bench for the host port against the memory model.
   assumes the host takes one request at a time while ready. */
`timescale 1ns/1ps
`default_nettype none
module bytewide_nv_memory_port_tb;
  logic clk_in = 1'b0, rstn_in = 1'b0, supply_ok_in = 1'b1, req_in = 1'b0, req_wr_in = 1'b0;
  logic [12:0] req_addr_in = 13'h0000, address_bus_out;
  logic [7:0] req_wdata_in = 8'h00, rd_data_out, data_bus_out, data_bus_in, m_q, m_d;
  logic req_ready_out, rd_valid_out, cs_n_out, we_n_out, oe_n_out, data_bus_oe_out, m_oe;
  int err_count = 0, cmp_count = 0;
  always #50 clk_in = ~clk_in;
  assign data_bus_in = m_oe ? m_q : ~m_q;
  // a released host bus shows the inverse so early release corrupts the write
  assign m_d = data_bus_oe_out ? data_bus_out : ~data_bus_out;
  bnm_host u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .supply_ok_in(supply_ok_in),
    .req_in(req_in), .req_wr_in(req_wr_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .address_bus_out(address_bus_out), .cs_n_out(cs_n_out),
    .we_n_out(we_n_out), .oe_n_out(oe_n_out), .data_bus_out(data_bus_out),
    .data_bus_oe_out(data_bus_oe_out), .data_bus_in(data_bus_in));
  bnm_mem_model u_mem (.cs_n_in(cs_n_out), .we_n_in(we_n_out), .oe_n_in(oe_n_out),
    .addr_in(address_bus_out), .d_in(m_d), .q_out(m_q), .q_oe_out(m_oe));
  task automatic conclude;
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    // start off the edge that may have just taken the previous request
    @(negedge clk_in);
    while (req_ready_out !== 1'b1 && n < 50)
    begin
      @(negedge clk_in);
      n++;
    end
    chk({7'h00, req_ready_out}, 8'h01);
    @(posedge clk_in);
    req_in <= 1'b1;
    req_wr_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    @(posedge clk_in);
    req_in <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    int n;
    acc(1'b0, a, 8'h00);
    n = 0;
    while (rd_valid_out !== 1'b1 && n < 20)
    begin
      @(negedge clk_in);
      n++;
    end
    chk({7'h00, rd_valid_out}, 8'h01);
    chk(rd_data_out, e);
  endtask
  task automatic t_rows;
    acc(1'b1, 13'h0000, 8'h5a);
    acc(1'b1, 13'h0007, 8'ha5);
    acc(1'b1, 13'h0008, 8'h3c);
    rd(13'h0000, 8'h5a);
    rd(13'h0007, 8'ha5);
    rd(13'h0008, 8'h3c);
    chk(u_mem.row_use[0][7:0], 8'h04);
    chk(u_mem.row_use[1][7:0], 8'h02);
  endtask
  task automatic t_edges;
    acc(1'b1, 13'h1fff, 8'hff);
    acc(1'b1, 13'h0fff, 8'h00);
    rd(13'h1fff, 8'hff);
    rd(13'h0fff, 8'h00);
  endtask
  task automatic t_supply;
    @(posedge clk_in);
    supply_ok_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    req_in <= 1'b1;
    repeat (6)
    begin
      @(negedge clk_in);
      chk({7'h00, req_ready_out}, 8'h00);
      chk({7'h00, cs_n_out}, 8'h01);
    end
    @(posedge clk_in);
    req_in <= 1'b0;
    supply_ok_in <= 1'b1;
    rd(13'h1fff, 8'hff);
  endtask
  task automatic t_reset;
    acc(1'b1, 13'h0010, 8'h77);
    // reset lands on the edge that took the write, before chip select can fall
    rstn_in <= 1'b0;
    @(negedge clk_in);
    chk({5'h00, cs_n_out, we_n_out, data_bus_oe_out}, 8'h06);
    chk({7'h00, req_ready_out}, 8'h00);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(13'h0007, 8'ha5);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_rows;
    t_edges;
    t_supply;
    t_reset;
    conclude;
  end
  initial
  begin
    #200000;
    err_count++;
    conclude;
  end
endmodule
`default_nettype wire
